//--- rtl/flash_host_ctrl.sv
// Host-side controller that issues command sequences to a parallel flash over its strobes
// Summary of operation
// [R1] Reads drive chip select and output gate low, write strobe high, sample data.
// [R2] Host releases data bus whenever output gate is low or chip select high.
// [R3] Chip erase: six writes ending 80 then 10.
// [R4] After chip erase the device is back in read mode; host polls completion.
// [R5] Main erase sets non-boot words to FFFF; host issues command, then polls completion.
// [R6] Main erase sixth write is 30 to 5555, then host polls completion.
// [R7] Programming only clears bits; erase needed to set them back.
// [R8] Word program: AA/5555, 55/2AAA, A0/5555, then address and data.
// [R9] Address set before strobe falls, data held past strobe rising edge.
// [R10] Boot block 0000-1FFF rejects program and erase once locked.
// [R11] Lockout: AA,55,80,AA,55 then 40 to 5555.
// [R12] Lock status read at 0002 in identification mode, low bit.
// [R13] ID entry AA,55,90; exit AA,55,F0 or single F0 anywhere.
// [R14] Only low data byte matters in commands; upper byte driven zero.
// [R15] Identification codes readable at addresses 0000 and 0001.
// [R16] Polling read returns complement on the poll bit until done.
// [R17] Toggle bit flips each read while busy; host waits until stable.
// [R18] Host polls after program or erase, no new access until complete.
// [R19] Writes keep output gate high and chip select, write strobe low.
// [R20] Strobe low pulses far exceed the noise filter width.
// [R21] Host only issues whole valid sequences, never stray command words.
`timescale 1ns/1ps
module flash_host_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // User request side
   input wire logic req_valid,
   input wire flash_host_pkg::req_s req,
   output logic req_ready,
   output logic done_pulse,
   output logic [15:0] rd_data,
   // Flash pins
   output logic [15:0] flash_addr,
   input wire logic [15:0] flash_dq_in,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe,
   output logic ce_n,
   output logic oe_n,
   output logic we_n
);
   typedef enum logic [2:0] {S_IDLE, S_SETUP, S_WLOW, S_WHOLD, S_RACC, S_POLL, S_DONE} state_e;

   state_e state_ff, nxt_state;
   flash_host_pkg::req_s req_ff, nxt_req;
   logic [2:0] step_ff, nxt_step;
   logic [3:0] cnt_ff, nxt_cnt;
   logic poll_ff, nxt_poll;
   logic last_tog_ff, nxt_last_tog;
   logic [15:0] rd_ff, nxt_rd;
   logic [15:0] addr_ff, nxt_addr;
   logic [15:0] dout_ff, nxt_dout;
   logic ce_ff, nxt_ce, oe_ff, nxt_oe, we_ff, nxt_we, dq_oe_ff, nxt_dq_oe;
   logic [15:0] dq_meta_ff, dq_sync_ff;

   // Number of writes for each operation
   function automatic logic [2:0] op_len(input flash_host_pkg::op_e op);
      unique case (op)
         flash_host_pkg::OP_PROGRAM: op_len = 3'h4;
         flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_MAIN_ERASE,
         flash_host_pkg::OP_LOCKOUT: op_len = 3'h6;
         flash_host_pkg::OP_ID_ENTRY, flash_host_pkg::OP_ID_EXIT: op_len = 3'h3;
         flash_host_pkg::OP_ID_EXIT_SHORT: op_len = 3'h1;
         flash_host_pkg::OP_READ: op_len = 3'h0;
      endcase
   endfunction : op_len

   // Final command byte of a sequence
   function automatic logic [7:0] op_code(input flash_host_pkg::op_e op);
      unique case (op)
         flash_host_pkg::OP_CHIP_ERASE: op_code = flash_host_pkg::CMD_CHIP_ERASE; // [R3]
         flash_host_pkg::OP_MAIN_ERASE: op_code = flash_host_pkg::CMD_MAIN_ERASE; // [R6]
         flash_host_pkg::OP_LOCKOUT: op_code = flash_host_pkg::CMD_LOCKOUT; // [R11]
         flash_host_pkg::OP_ID_ENTRY: op_code = flash_host_pkg::CMD_ID_ENTRY; // [R13]
         flash_host_pkg::OP_PROGRAM: op_code = flash_host_pkg::CMD_PROGRAM; // [R8]
         default: op_code = flash_host_pkg::CMD_ID_EXIT; // [R13]
      endcase
   endfunction : op_code

   // Address and data of write number step (1-based) of a sequence
   function automatic flash_host_pkg::cycle_s seq_cycle(input flash_host_pkg::req_s r,
                                                        input logic [2:0] step);
      flash_host_pkg::cycle_s c;
      c.addr = flash_host_pkg::UNLOCK_ADDR1;
      c.data = {8'h00, flash_host_pkg::CMD_UNLOCK1}; // [R14]
      if (r.op == flash_host_pkg::OP_ID_EXIT_SHORT) begin
         c.addr = r.addr;
         c.data = {8'h00, flash_host_pkg::CMD_ID_EXIT}; // [R13]
      end else if (step == 3'h2 || step == 3'h5) begin
         c.addr = flash_host_pkg::UNLOCK_ADDR2;
         c.data = {8'h00, flash_host_pkg::CMD_UNLOCK2};
      end else if (step == 3'h3) begin
         c.data = {8'h00, (op_len(r.op) == 3'h6) ? flash_host_pkg::CMD_SETUP_ERASE
                                                   : op_code(r.op)};
      end else if (step == 3'h4 && r.op == flash_host_pkg::OP_PROGRAM) begin
         c.addr = r.addr; // [R8]
         c.data = r.data; // [R7]
      end else if (step == 3'h6) begin
         c.data = {8'h00, op_code(r.op)};
      end
      seq_cycle = c;
   endfunction : seq_cycle

   // Needs status polling after the last write
   function automatic logic op_busy(input flash_host_pkg::op_e op);
      op_busy = (op == flash_host_pkg::OP_PROGRAM) || (op == flash_host_pkg::OP_CHIP_ERASE) ||
                (op == flash_host_pkg::OP_MAIN_ERASE) || (op == flash_host_pkg::OP_LOCKOUT);
   endfunction : op_busy

   // Read data comes from a pin, so it passes two flops first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dq_meta_ff <= 16'h0000;
         dq_sync_ff <= 16'h0000;
      end else if (clk_en) begin
         dq_meta_ff <= flash_dq_in;
         dq_sync_ff <= dq_meta_ff;
      end
   end

   always_comb begin
      flash_host_pkg::cycle_s cyc;
      cyc = seq_cycle(req_ff, step_ff);
      nxt_state = state_ff;
      nxt_req = req_ff;
      nxt_step = step_ff;
      nxt_cnt = cnt_ff;
      nxt_poll = poll_ff;
      nxt_last_tog = last_tog_ff;
      nxt_rd = rd_ff;
      nxt_addr = addr_ff;
      nxt_dout = dout_ff;
      nxt_ce = ce_ff;
      nxt_oe = oe_ff;
      nxt_we = we_ff;
      nxt_dq_oe = dq_oe_ff;
      unique case (state_ff)
         S_IDLE: begin
            nxt_ce = 1'b1;
            nxt_oe = 1'b1;
            nxt_we = 1'b1;
            nxt_dq_oe = 1'b0;
            if (req_valid) begin
               nxt_req = req;
               nxt_step = flash_host_pkg::STEP_ONE;
               nxt_poll = 1'b0;
               nxt_cnt = flash_host_pkg::CNT_SETUP;
               if (req.op == flash_host_pkg::OP_READ) begin
                  nxt_addr = req.addr;
                  nxt_ce = 1'b0; // [R1]
                  nxt_oe = 1'b0;
                  nxt_cnt = flash_host_pkg::CNT_READ;
                  nxt_state = S_RACC;
               end else begin
                  nxt_state = S_SETUP;
               end
            end
         end
         S_SETUP: begin
            // Address and data settle with output gate high before the strobe falls
            nxt_addr = cyc.addr; // [R9]
            nxt_dout = cyc.data;
            nxt_oe = 1'b1; // [R19]
            nxt_dq_oe = 1'b1; // [R2]
            nxt_ce = 1'b0;
            // Strobe falls only after the address has stood a full setup count
            if (cnt_ff < flash_host_pkg::CNT_ONE) begin // [R9]
               nxt_we = 1'b0; // [R19]
               nxt_cnt = flash_host_pkg::CNT_LOW;
               nxt_state = S_WLOW;
            end else begin
               nxt_cnt = cnt_ff - flash_host_pkg::CNT_ONE;
            end
         end
         S_WLOW: begin
            // Low time is several clocks, well above the device noise filter
            if (cnt_ff <= flash_host_pkg::CNT_ONE) begin // [R20]
               nxt_we = 1'b1;
               nxt_cnt = flash_host_pkg::CNT_SETUP;
               nxt_state = S_WHOLD;
            end else begin
               nxt_cnt = cnt_ff - flash_host_pkg::CNT_ONE;
            end
         end
         S_WHOLD: begin
            // Data and address held one period past the rising edge
            if (cnt_ff <= flash_host_pkg::CNT_ONE) begin // [R9]
               nxt_ce = 1'b1;
               nxt_dq_oe = 1'b0;
               nxt_cnt = flash_host_pkg::CNT_SETUP;
               if (step_ff != op_len(req_ff.op)) begin // [R21]
                  nxt_step = step_ff + flash_host_pkg::STEP_ONE;
                  nxt_state = S_SETUP;
               end else if (op_busy(req_ff.op)) begin
                  nxt_poll = 1'b1; // [R18]
                  if (req_ff.op == flash_host_pkg::OP_PROGRAM) begin
                     nxt_addr = req_ff.addr; // [R16]
                  end
                  nxt_ce = 1'b0;
                  nxt_oe = 1'b0;
                  nxt_cnt = flash_host_pkg::CNT_READ;
                  nxt_state = S_RACC;
               end else begin
                  nxt_state = S_DONE; // [R4]
               end
            end else begin
               nxt_cnt = cnt_ff - flash_host_pkg::CNT_ONE;
            end
         end
         S_RACC: begin
            // Waits out the access time only; the two synchroniser flops fall inside that count
            if (cnt_ff <= flash_host_pkg::CNT_ONE) begin
               nxt_rd = dq_sync_ff; // [R1]
               nxt_ce = 1'b1;
               nxt_oe = 1'b1;
               nxt_cnt = flash_host_pkg::CNT_SETUP;
               // Previous read's toggle bit, so the poll compares two different reads
               nxt_last_tog = rd_ff[flash_host_pkg::TOGGLE_BIT]; // [R17]
               nxt_state = poll_ff ? S_POLL : S_DONE;
            end else begin
               nxt_cnt = cnt_ff - flash_host_pkg::CNT_ONE;
            end
         end
         S_POLL: begin
            // Two reads with equal toggle bit mean the operation finished
            if (cnt_ff <= flash_host_pkg::CNT_ONE) begin
               nxt_ce = 1'b0;
               nxt_oe = 1'b0;
               nxt_cnt = flash_host_pkg::CNT_READ;
               if (step_ff == flash_host_pkg::STEP_ONE) begin
                  if (rd_ff[flash_host_pkg::TOGGLE_BIT] == last_tog_ff) begin // [R17]
                     nxt_ce = 1'b1;
                     nxt_oe = 1'b1;
                     nxt_state = S_DONE;
                  end else begin
                     nxt_last_tog = rd_ff[flash_host_pkg::TOGGLE_BIT];
                     nxt_state = S_RACC;
                  end
               end else begin
                  nxt_step = flash_host_pkg::STEP_ONE;
                  nxt_state = S_RACC;
               end
            end else begin
               nxt_cnt = cnt_ff - flash_host_pkg::CNT_ONE;
            end
         end
         S_DONE: begin
            nxt_state = S_IDLE;
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= S_IDLE;
         req_ff <= '0;
         step_ff <= 3'h0;
         cnt_ff <= 4'h0;
         poll_ff <= 1'b0;
         last_tog_ff <= 1'b0;
         rd_ff <= 16'h0000;
         addr_ff <= 16'h0000;
         dout_ff <= 16'h0000;
         ce_ff <= 1'b1;
         oe_ff <= 1'b1;
         we_ff <= 1'b1;
         dq_oe_ff <= 1'b0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         req_ff <= nxt_req;
         step_ff <= nxt_step;
         cnt_ff <= nxt_cnt;
         poll_ff <= nxt_poll;
         last_tog_ff <= nxt_last_tog;
         rd_ff <= nxt_rd;
         addr_ff <= nxt_addr;
         dout_ff <= nxt_dout;
         ce_ff <= nxt_ce;
         oe_ff <= nxt_oe;
         we_ff <= nxt_we;
         dq_oe_ff <= nxt_dq_oe;
      end
   end

   assign req_ready = (state_ff == S_IDLE);
   assign done_pulse = (state_ff == S_DONE);
   assign rd_data = rd_ff;
   assign flash_addr = addr_ff;
   assign flash_dq_out = dout_ff;
   assign flash_dq_oe = dq_oe_ff;
   assign ce_n = ce_ff;
   assign oe_n = oe_ff;
   assign we_n = we_ff;
endmodule : flash_host_ctrl

//--- rtl/flash_host_pkg.sv
// Package: command codes, addresses, timing and carriers for the flash host controller
package flash_host_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam logic [15:0] UNLOCK_ADDR1 = 16'h5555;
   localparam logic [15:0] UNLOCK_ADDR2 = 16'h2AAA;
   localparam logic [15:0] ID_LOCK_ADDR = 16'h0002;
   localparam logic [15:0] ID_MFR_ADDR = 16'h0000;
   localparam logic [15:0] ID_DEV_ADDR = 16'h0001;
   localparam logic [15:0] BOOT_LAST = 16'h1FFF;
   localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
   localparam logic [7:0] CMD_SETUP_ERASE = 8'h80;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CMD_MAIN_ERASE = 8'h30;
   localparam logic [7:0] CMD_PROGRAM = 8'hA0;
   localparam logic [7:0] CMD_LOCKOUT = 8'h40;
   localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
   localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int LOCK_BIT = 0;
   // Strobe timing in ns at a 20 ns clock
   localparam int CLK_NS = 20;
   localparam int STROBE_LOW_NS = 60;
   localparam int SETUP_NS = 20;
   localparam int READ_ACC_NS = 100;
   localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_ACC_CYC = (READ_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] CNT_LOW = 4'(STROBE_LOW_CYC);
   localparam logic [3:0] CNT_SETUP = 4'(SETUP_CYC);
   localparam logic [3:0] CNT_READ = 4'(READ_ACC_CYC);
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [2:0] STEP_ONE = 3'h1;

   typedef enum logic [2:0] {
      OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_MAIN_ERASE, OP_LOCKOUT,
      OP_ID_ENTRY, OP_ID_EXIT, OP_ID_EXIT_SHORT
   } op_e;

   typedef struct packed {
      op_e op;
      logic [15:0] addr;
      logic [15:0] data;
   } req_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] data;
   } cycle_s;
endpackage : flash_host_pkg

//--- verif/flash_host_ctrl_monitor.sv
// Checker of strobe, bus and sequencing relations at the flash host controller pins
`timescale 1ns/1ps
module flash_host_ctrl_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // User side
   input wire logic req_valid,
   input wire flash_host_pkg::req_s req,
   input wire logic req_ready,
   input wire logic done_pulse,
   input wire logic [15:0] rd_data,
   // Flash pins
   input wire logic [15:0] flash_addr,
   input wire logic [15:0] flash_dq_in,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_oe,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_take;
      req_valid && req_ready && clk_en && req.op != flash_host_pkg::OP_READ
         && req.op != flash_host_pkg::OP_ID_EXIT_SHORT;
   endsequence
   sequence s_first_fall;
      s_take ##2 we_n ##1 !we_n;
   endsequence
   no_contend_a: assert property (flash_dq_oe |-> oe_n) else $error("bus driven in read");
   read_mode_a: assert property (!oe_n |-> !ce_n && we_n && !flash_dq_oe)
      else $error("bad read strobes");
   read_len_a: assert property ($fell(oe_n) |-> (!oe_n) [*5]) else $error("read too short");
   write_mode_a: assert property (!we_n |-> !ce_n && oe_n && flash_dq_oe)
      else $error("bad write strobes");
   we_width_a: assert property ($fell(we_n) |-> (!we_n) [*3] ##1 we_n)
      else $error("write pulse width");
   addr_setup_a: assert property ($fell(we_n) |-> $stable(flash_addr) && $past(!ce_n))
      else $error("address setup");
   data_hold_a: assert property ($rose(we_n) |-> !ce_n ##1 $stable(flash_dq_out))
      else $error("data hold");
   unlock_first_a: assert property (s_first_fall |-> flash_addr == 16'h5555
      && flash_dq_out[7:0] == 8'hAA) else $error("first write not unlock");
   upper_zero_a: assert property (!we_n && flash_addr == 16'h2AAA
      |-> flash_dq_out == 16'h0055) else $error("unlock word wrong");
   done_ready_a: assert property (done_pulse |=> req_ready && !done_pulse)
      else $error("done not single");
   idle_quiet_a: assert property (req_ready |-> ce_n && we_n) else $error("access while idle");
endmodule : flash_host_ctrl_monitor

bind flash_host_ctrl flash_host_ctrl_monitor i_mon (.clk(clk), .rst(rst), .clk_en(clk_en),
   .req_valid(req_valid), .req(req), .req_ready(req_ready), .done_pulse(done_pulse),
   .rd_data(rd_data), .flash_addr(flash_addr), .flash_dq_in(flash_dq_in),
   .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .ce_n(ce_n), .oe_n(oe_n),
   .we_n(we_n));

//--- verif/flash_model.sv
// Behavioural parallel flash driven by its strobes
`timescale 1ns/1ps
module flash_model #(
   parameter logic [15:0] MFR_CODE = 16'h00A5, // Arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h005A // Arbitrary value
) (
   // Pins
   input wire logic [15:0] addr,
   input wire logic [15:0] dq_in,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   output logic [15:0] dq
);
   logic [15:0] mem [logic [15:0]];
   logic [15:0] la = 16'h0000, last = 16'h0000, pd = 16'h0000;
   logic tog = 1'b0, idm = 1'b0, lock = 1'b0;
   int step = 0, busy = 0;
   time t_fall = 0;
   function automatic logic [15:0] rv(logic [15:0] a, int b, logic t, logic i);
      if (b > 0) return {8'h00, ~pd[7], t, 6'h00};
      if (i && a == 16'h0000) return MFR_CODE;
      if (i && a == 16'h0001) return DEV_CODE;
      if (i && a == 16'h0002) return {15'h0000, lock};
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction : rv
   task automatic ers(input logic [7:0] c);
      logic [15:0] ks[$];
      if (c == 8'h40) lock = 1'b1;
      foreach (mem[k])
         if ((c == 8'h10 && !(lock && k <= 16'h1FFF)) || (c == 8'h30 && k > 16'h1FFF))
            ks.push_back(k);
      foreach (ks[i]) mem.delete(ks[i]);
      busy = 3;
      pd = 16'h0080;
   endtask : ers
   task automatic cmd(input logic [15:0] a, input logic [15:0] d);
      int s;
      logic u1;
      s = step;
      u1 = a[14:0] == 15'h5555;
      step = 0;
      if (s == 3 && !(lock && a <= 16'h1FFF)) begin
         mem[a] = rv(a, 0, 1'b0, 1'b0) & d;
         busy = 3;
         pd = d;
      end
      if ((s == 0 || s == 4) && u1 && d[7:0] == 8'hAA) step = s + 1;
      if ((s == 1 || s == 5) && a[14:0] == 15'h2AAA && d[7:0] == 8'h55) step = s + 1;
      if (s == 0 && d[7:0] == 8'hF0) idm = 1'b0;
      if (u1 && s == 2 && d[7:0] == 8'hA0) step = 3;
      if (u1 && s == 2 && d[7:0] == 8'h80) step = 4;
      if (u1 && s == 2 && d[7:0] == 8'h90) idm = 1'b1;
      if (u1 && s == 2 && d[7:0] == 8'hF0) idm = 1'b0;
      if (u1 && s == 6) ers(d[7:0]);
   endtask : cmd
   // Address at the later fall, data at the earlier rise; short pulses ignored
   always @(negedge we_n) if (!ce_n && oe_n) t_fall = $time;
   always @(negedge we_n) if (!ce_n && oe_n) la = addr;
   always @(posedge we_n) if (!ce_n && oe_n && $time - t_fall >= 15) cmd(la, dq_in);
   always @(posedge oe_n) begin
      if (we_n) begin
         last = rv(addr, busy, tog, idm);
         if (busy > 0) begin
            tog = ~tog;
            busy--;
         end
      end
   end
   // Released bus shows the inverse of the last word so stale data cannot pass
   assign dq = (!ce_n && !oe_n && we_n) ? rv(addr, busy, tog, idm) : ~last;
endmodule : flash_model

//--- verif/test_flash_host_ctrl.sv
// Self-checking bench for the flash host controller against a behavioural flash
`timescale 1ns/1ps
module test_flash_host_ctrl;
   localparam logic [15:0] MFR_CODE = 16'h00A5; // Arbitrary value
   localparam logic [15:0] DEV_CODE = 16'h005A; // Arbitrary value
   logic clk, rst, clk_en, req_valid, req_ready, done_pulse, flash_dq_oe, ce_n, oe_n, we_n;
   flash_host_pkg::req_s req;
   logic [15:0] rd_data, flash_addr, flash_dq_in, flash_dq_out, mdl_dq;
   int miscompares = 0;
   int n_checks = 0;
   assign flash_dq_in = flash_dq_oe ? flash_dq_out : mdl_dq;
   flash_host_ctrl i_dut (.clk(clk), .rst(rst), .clk_en(clk_en), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .done_pulse(done_pulse), .rd_data(rd_data),
      .flash_addr(flash_addr), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
      .flash_dq_oe(flash_dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
   flash_model #(.MFR_CODE(MFR_CODE), .DEV_CODE(DEV_CODE)) i_flash (.addr(flash_addr),
      .dq_in(flash_dq_in), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq(mdl_dq));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Ready stays low through the done cycle, so wait for idle before raising the request
   task automatic op(input flash_host_pkg::op_e o, input logic [15:0] a, input logic [15:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      req = '{o, a, d};
      req_valid = 1'b1;
      @(posedge clk);
      #1 req_valid = 1'b0;
      while (done_pulse !== 1'b1 && n < 3000) begin
         @(posedge clk);
         #1 n++;
      end
      chk({15'h0000, done_pulse}, 16'h0001);
   endtask : op
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      op(flash_host_pkg::OP_READ, a, 16'h0000);
      chk(rd_data, exp);
   endtask : rd
   task automatic t_program;
      rd(16'h3000, 16'hFFFF);
      op(flash_host_pkg::OP_PROGRAM, 16'h3000, 16'h1234);
      chk(rd_data, 16'h1234);
      op(flash_host_pkg::OP_PROGRAM, 16'h3000, 16'hFF0F);
      rd(16'h3000, 16'h1204);
   endtask : t_program
   task automatic t_chip_erase;
      op(flash_host_pkg::OP_PROGRAM, 16'h0010, 16'h1234);
      op(flash_host_pkg::OP_CHIP_ERASE, 16'h0000, 16'h0000);
      rd(16'h0010, 16'hFFFF);
      rd(16'h3000, 16'hFFFF);
   endtask : t_chip_erase
   task automatic t_ident;
      op(flash_host_pkg::OP_ID_ENTRY, 16'h0000, 16'h0000);
      rd(flash_host_pkg::ID_MFR_ADDR, MFR_CODE);
      rd(flash_host_pkg::ID_DEV_ADDR, DEV_CODE);
      rd(flash_host_pkg::ID_LOCK_ADDR, 16'h0000);
      op(flash_host_pkg::OP_ID_EXIT_SHORT, 16'h7777, 16'h0000);
      rd(16'h0000, 16'hFFFF);
   endtask : t_ident
   task automatic t_lockout;
      op(flash_host_pkg::OP_PROGRAM, 16'h1FFF, 16'h00FF);
      op(flash_host_pkg::OP_PROGRAM, 16'h2000, 16'h0F0F);
      op(flash_host_pkg::OP_LOCKOUT, 16'h0000, 16'h0000);
      op(flash_host_pkg::OP_ID_ENTRY, 16'h0000, 16'h0000);
      rd(flash_host_pkg::ID_LOCK_ADDR, 16'h0001);
      op(flash_host_pkg::OP_ID_EXIT, 16'h0000, 16'h0000);
      rd(16'h0001, 16'hFFFF);
      op(flash_host_pkg::OP_PROGRAM, 16'h1FFF, 16'h0000);
      rd(16'h1FFF, 16'h00FF);
      op(flash_host_pkg::OP_MAIN_ERASE, 16'h0000, 16'h0000);
      rd(16'h2000, 16'hFFFF);
      rd(16'h1FFF, 16'h00FF);
      op(flash_host_pkg::OP_PROGRAM, 16'h2000, 16'h0000);
      op(flash_host_pkg::OP_CHIP_ERASE, 16'h0000, 16'h0000);
      rd(16'h2000, 16'hFFFF);
      rd(16'h1FFF, 16'h00FF);
   endtask : t_lockout
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      req_valid = 1'b0;
      req = '0;
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      t_program();
      t_chip_erase();
      t_ident();
      t_lockout();
      wrap_up();
   end
   // Whole run is about a thousand cycles; this allows about 50000
   initial begin
      #1000000;
      miscompares++;
      wrap_up();
   end
endmodule : test_flash_host_ctrl
